// *** logic/mio_defs.svh ***
// Constants of the slot block: offsets, fields, responses, timing.
// Assumes a 100 MHz aclk; cycle counts derive from that rate.
`ifndef MIO_DEFS_SVH
`define MIO_DEFS_SVH
`define MIO_CLK_HZ 100000000
`define MIO_WD_MS 100
`define MIO_FILT_DEF_US 3000
`define MIO_FILT_MIN_US 10
`define MIO_WD_CYC (`MIO_WD_MS * (`MIO_CLK_HZ / 1000))
`define MIO_FILT_DEF_CYC (`MIO_FILT_DEF_US * (`MIO_CLK_HZ / 1000000))
`define MIO_FILT_MIN_CYC ((`MIO_FILT_MIN_US * `MIO_CLK_HZ + 999999) / 1000000)
`define MIO_OFS_SLOT_CFG 8'h00
`define MIO_OFS_OUT_CTRL 8'h04
`define MIO_OFS_PWM_DUTY 8'h08
`define MIO_OFS_FILT_TIME 8'h0C
`define MIO_OFS_STATUS 8'h10
`define MIO_OFS_IRQ_STAT 8'h14
`define MIO_OFS_IRQ_MASK 8'h18
`define MIO_OFS_LATCH_CFG 8'h1C
`define MIO_OFS_POSITION 8'h20
`define MIO_OFS_LATCHED 8'h24
`define MIO_OFS_ANALOG 8'h28
`define MIO_IRQ_WD_BIT 0
`define MIO_IRQ_IN_BIT 1
`define MIO_STAT_WD_BIT 12
`define MIO_DUTY_FULL 16'hFFFF
`define MIO_DUTY_ZERO 16'h0000
`define MIO_RESP_OKAY 2'h0
`define MIO_RESP_SLVERR 2'h2
`endif

// *** logic/mio_pkg.sv ***
// Types of the slot block: per-slot module selections.
// Assumes mio_defs.svh holds all numeric constants.
package mio_pkg;
    typedef enum logic [1:0] {S1_NONE = 2'h0, S1_QUAD = 2'h1, S1_COUNT = 2'h2,
        S1_DIO = 2'h3} mio_s1_mode_t;
    typedef enum logic [1:0] {S2_NONE = 2'h0, S2_DIO = 2'h1, S2_PWM = 2'h2,
        S2_RSVD = 2'h3} mio_s2_mode_t;
    typedef enum logic [1:0] {S3_NONE = 2'h0, S3_DI = 2'h1, S3_R2 = 2'h2,
        S3_R3 = 2'h3} mio_s3_mode_t;
    typedef enum logic [1:0] {S4_NONE = 2'h0, S4_ANALOG = 2'h1, S4_DI = 2'h2,
        S4_RSVD = 2'h3} mio_s4_mode_t;
    // One field per slot: at most one module each.
    typedef struct packed {
        mio_s4_mode_t s4;
        mio_s3_mode_t s3;
        mio_s2_mode_t s2;
        mio_s1_mode_t s1;
    } mio_slot_cfg_t;
    typedef struct packed {
        logic in_change;
        logic wd_fail;
    } mio_irq_t;
endpackage

// *** logic/mio_debounce.sv ***
// Pin synchroniser and debounce filter for one field input.
// Assumes pin_i is asynchronous and limit_i is on aclk.
module mio_debounce #(
    parameter int CW = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_i,
    input wire logic [CW-1:0] limit_i,
    output logic sync_o,
    output logic filt_o
);
    logic meta_q;
    logic sync_q;
    logic filt_q;
    logic [CW-1:0] cnt_q;

    // Two flops before anything looks at the pin.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    // A level is taken once it held for limit_i cycles; a bounce restarts.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            filt_q <= 1'b0;
            cnt_q <= '0;
        end
        else if (sync_q == filt_q)
        begin
            cnt_q <= '0;
        end
        else if (cnt_q >= limit_i - CW'(1))
        begin
            filt_q <= sync_q;
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    assign sync_o = sync_q;
    assign filt_o = filt_q;
endmodule // mio_debounce

// *** logic/mio_pwm_stage.sv ***
// Pulse-width output stage for one output pin.
// Assumes duty_i is on aclk; the period is 65536 cycles.
`include "mio_defs.svh"
module mio_pwm_stage (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] duty_i,
    output logic pwm_o
);
    logic [15:0] phase_q;
    logic pwm_q;

    // Free-running phase; the end values bypass it so the level is static.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            phase_q <= 16'h0000;
            pwm_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_q + 16'h0001;
            if (duty_i == `MIO_DUTY_ZERO)
                pwm_q <= 1'b0;
            else if (duty_i == `MIO_DUTY_FULL)
                pwm_q <= 1'b1;
            else
                pwm_q <= (phase_q < duty_i);
        end
    end

    assign pwm_o = pwm_q;
endmodule // mio_pwm_stage

// *** logic/mio_slot_mux.sv ***
// Top of the slot block: AXI4-Lite registers, slot decode, input filters,
// position counter, output routing, watchdog and interrupt.
// Assumes field pins and converter words are asynchronous to aclk.
`include "mio_defs.svh"
module mio_slot_mux
    import mio_pkg::*;
// Notes on behaviour
// - Four slots, each owning fixed pins; the chosen module sets pin behaviour.
// - One module per slot; mode comes only from it, none means unused.
// - Host traffic gaps over 100 ms are flagged as failure; host must be faster.
// - Slot one owns inputs 1-2, input 3 in encoder mode, outputs 1-2.
// - Encoder mode decodes two tracks up to 250 kHz, drives two outputs.
// - Counter mode counts input 1, direction from input 2, drives two outputs.
// - Input 3 high in encoder mode latches position or clears it, as configured.
// - Slot two owns inputs 3-4, outputs 3-4; plain digital or pulse-width.
// - Slot three owns inputs 5-6 as one digital pair with the configurable filter.
// - Slot four owns inputs 7-8: digital or two 12-bit analog values.
// - All digital inputs are debounced, default 3 ms, minimum 10 us.
// - Only inputs 3 to 6 take the configurable filter time.
// - Eight inputs, four outputs, each with an indicator of its state.
// - Duty 0x0000 holds a pulse-width output off, 0xFFFF holds it on.
#(
    parameter int unsigned WD_CYCLES = `MIO_WD_CYC,
    parameter int unsigned FILT_DEF_CYCLES = `MIO_FILT_DEF_CYC,
    parameter int FCW = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] field_in,
    input wire logic [11:0] adc_ch7,
    input wire logic [11:0] adc_ch8,
    output logic [3:0] field_out,
    output logic [7:0] led_in,
    output logic [3:0] led_out,
    output logic irq
);
    import mio_pkg::*;

    localparam logic [FCW-1:0] FILT_DEF = FCW'(FILT_DEF_CYCLES);
    localparam logic [FCW-1:0] FILT_MIN = FCW'(`MIO_FILT_MIN_CYC);

    mio_slot_cfg_t slot_cfg_q;
    logic [3:0] out_ctrl_q;
    logic [31:0] duty_q;
    logic [FCW-1:0] filt_time_q;
    mio_irq_t irq_stat_q;
    mio_irq_t irq_mask_q;
    logic latch_clr_q;
    logic [31:0] pos_q;
    logic [31:0] latched_q;
    logic [23:0] adc_meta_q;
    logic [23:0] adc_q;
    logic [31:0] wd_cnt_q;
    logic wd_fail_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [7:0] in_prev_q;
    logic [1:0] trk_prev_q;
    logic [7:0] pin_sync;
    logic [7:0] pin_filt;
    logic [1:0] pwm_lvl;
    logic [3:0] out_d;
    logic [7:0] in_state;
    logic [31:0] rd_d;
    logic rd_ok;
    logic wr_ok;
    logic do_wr;
    logic ar_hs;
    logic kick;
    logic [31:0] wmask;

    // Inputs 3 to 6 use the software filter time; the rest keep the default.
    for (genvar i = 0; i < 8; i++)
    begin : g_in
        localparam bit CFG_FILT = (i >= 2) && (i <= 5);
        mio_debounce #(
            .CW(FCW)
        ) u_deb (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin_i(field_in[i]),
            .limit_i(CFG_FILT ? filt_time_q : FILT_DEF),
            .sync_o(pin_sync[i]),
            .filt_o(pin_filt[i])
        );
    end

    // Outputs 3 and 4 each own a pulse-width stage.
    for (genvar j = 0; j < 2; j++)
    begin : g_pwm
        mio_pwm_stage u_pwm (
            .aclk(aclk),
            .aresetn(aresetn),
            .duty_i(duty_q[16*j +: 16]),
            .pwm_o(pwm_lvl[j])
        );
    end

    assign do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign kick = do_wr || ar_hs;
    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    // Address and data taken in either order, held until the response.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MIO_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_hold_q && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `MIO_RESP_OKAY : `MIO_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Writable offsets; status and counter words are read-only.
    always_comb
    begin
        case (awaddr_q)
            `MIO_OFS_SLOT_CFG, `MIO_OFS_OUT_CTRL, `MIO_OFS_PWM_DUTY, `MIO_OFS_FILT_TIME,
            `MIO_OFS_IRQ_STAT, `MIO_OFS_IRQ_MASK, `MIO_OFS_LATCH_CFG: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // Software registers; a filter time below the minimum is raised to it.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            slot_cfg_q <= '0;
            out_ctrl_q <= 4'h0;
            duty_q <= 32'h0000_0000;
            filt_time_q <= FILT_DEF;
            irq_mask_q <= '0;
            latch_clr_q <= 1'b0;
        end
        else if (do_wr)
        begin
            case (awaddr_q)
                `MIO_OFS_SLOT_CFG: if (wstrb_q[0]) slot_cfg_q <= wdata_q[7:0];
                `MIO_OFS_OUT_CTRL: if (wstrb_q[0]) out_ctrl_q <= wdata_q[3:0];
                `MIO_OFS_PWM_DUTY: duty_q <= (duty_q & ~wmask) | (wdata_q & wmask);
                `MIO_OFS_FILT_TIME:
                begin
                    if (wdata_q[FCW-1:0] < FILT_MIN)
                        filt_time_q <= FILT_MIN;
                    else
                        filt_time_q <= wdata_q[FCW-1:0];
                end
                `MIO_OFS_IRQ_MASK: if (wstrb_q[0]) irq_mask_q <= wdata_q[1:0];
                `MIO_OFS_LATCH_CFG: if (wstrb_q[0]) latch_clr_q <= wdata_q[0];
                default: ;
            endcase
        end
    end

    // Read channel answers one cycle after the address is taken.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MIO_RESP_OKAY;
        end
        else if (ar_hs)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_ok ? `MIO_RESP_OKAY : `MIO_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid;
        end
    end

    // Read mux; unmapped offsets return zero with an error response.
    always_comb
    begin
        rd_ok = 1'b1;
        rd_d = 32'h0000_0000;
        case (s_axi_araddr)
            `MIO_OFS_SLOT_CFG: rd_d[7:0] = slot_cfg_q;
            `MIO_OFS_OUT_CTRL: rd_d[3:0] = out_ctrl_q;
            `MIO_OFS_PWM_DUTY: rd_d = duty_q;
            `MIO_OFS_FILT_TIME: rd_d[FCW-1:0] = filt_time_q;
            `MIO_OFS_STATUS: rd_d[`MIO_STAT_WD_BIT:0] = {wd_fail_q, field_out, in_state};
            `MIO_OFS_IRQ_STAT: rd_d[1:0] = irq_stat_q;
            `MIO_OFS_IRQ_MASK: rd_d[1:0] = irq_mask_q;
            `MIO_OFS_LATCH_CFG: rd_d[0] = latch_clr_q;
            `MIO_OFS_POSITION: rd_d = pos_q;
            `MIO_OFS_LATCHED: rd_d = latched_q;
            `MIO_OFS_ANALOG: rd_d = {4'h0, adc_q[23:12], 4'h0, adc_q[11:0]};
            default: rd_ok = 1'b0;
        endcase
    end

    // Inputs seen by software; unused or analog slots read zero.
    always_comb
    begin
        in_state = 8'h00;
        if (slot_cfg_q.s1 != S1_NONE)
            in_state[1:0] = pin_filt[1:0];
        if (slot_cfg_q.s2 == S2_DIO || slot_cfg_q.s2 == S2_PWM)
            in_state[3:2] = pin_filt[3:2];
        else if (slot_cfg_q.s1 == S1_QUAD)
            in_state[2] = pin_filt[2];
        if (slot_cfg_q.s3 == S3_DI)
            in_state[5:4] = pin_filt[5:4];
        if (slot_cfg_q.s4 == S4_DI)
            in_state[7:6] = pin_filt[7:6];
    end

    // Converter words are resynchronised; the converter must hold a word steady.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            adc_meta_q <= 24'h00_0000;
            adc_q <= 24'h00_0000;
        end
        else
        begin
            adc_meta_q <= {adc_ch8, adc_ch7};
            if (slot_cfg_q.s4 == S4_ANALOG)
                adc_q <= adc_meta_q;
            else
                adc_q <= 24'h00_0000;
        end
    end

    // Position uses synced, unfiltered tracks; a 3 ms filter would eat them.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pos_q <= 32'h0000_0000;
            latched_q <= 32'h0000_0000;
            trk_prev_q <= 2'h0;
        end
        else
        begin
            trk_prev_q <= pin_sync[1:0];
            if (slot_cfg_q.s1 == S1_QUAD && pin_filt[2] && latch_clr_q)
                pos_q <= 32'h0000_0000;
            else if (slot_cfg_q.s1 == S1_QUAD && ^(pin_sync[1:0] ^ trk_prev_q))
                pos_q <= (trk_prev_q[0] ^ pin_sync[1]) ? pos_q + 32'h1 : pos_q - 32'h1;
            else if (slot_cfg_q.s1 == S1_COUNT && pin_sync[0] && !trk_prev_q[0])
                pos_q <= pin_sync[1] ? pos_q + 32'h1 : pos_q - 32'h1;
            if (slot_cfg_q.s1 == S1_QUAD && pin_filt[2] && !latch_clr_q)
                latched_q <= pos_q;
        end
    end

    // Output routing by slot; a failed host link forces every output off.
    always_comb
    begin
        out_d = 4'h0;
        if (slot_cfg_q.s1 != S1_NONE)
            out_d[1:0] = out_ctrl_q[1:0];
        if (slot_cfg_q.s2 == S2_DIO)
            out_d[3:2] = out_ctrl_q[3:2];
        else if (slot_cfg_q.s2 == S2_PWM)
            out_d[3:2] = pwm_lvl;
        if (wd_fail_q)
            out_d = 4'h0;
    end

    // Pins and indicators come straight from flops.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            field_out <= 4'h0;
            led_out <= 4'h0;
            led_in <= 8'h00;
        end
        else
        begin
            field_out <= out_d;
            led_out <= out_d;
            led_in <= pin_filt;
        end
    end

    // A write with both halves taken, or a read address taken, restarts the watchdog.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wd_cnt_q <= 32'h0000_0000;
            wd_fail_q <= 1'b0;
        end
        else if (kick)
        begin
            wd_cnt_q <= 32'h0000_0000;
            wd_fail_q <= 1'b0;
        end
        else if (wd_cnt_q >= WD_CYCLES - 1)
        begin
            wd_fail_q <= 1'b1;
        end
        else
        begin
            wd_cnt_q <= wd_cnt_q + 32'h1;
        end
    end

    // Sticky events, cleared by writing one; a new event wins over the clear.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_q <= '0;
            in_prev_q <= 8'h00;
            irq <= 1'b0;
        end
        else
        begin
            in_prev_q <= pin_filt;
            if (do_wr && awaddr_q == `MIO_OFS_IRQ_STAT && wstrb_q[0])
                irq_stat_q <= irq_stat_q & ~wdata_q[1:0];
            if (!wd_fail_q && wd_cnt_q >= WD_CYCLES - 1 && !kick)
                irq_stat_q[`MIO_IRQ_WD_BIT] <= 1'b1;
            if (pin_filt != in_prev_q)
                irq_stat_q[`MIO_IRQ_IN_BIT] <= 1'b1;
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule // mio_slot_mux

// *** tb/mio_slot_mux_checker.sv ***
// Port checker of the slot block, bound to every mio_slot_mux.
// Assumes two sync flops ahead of each filter counter.
module mio_slot_mux_checker #(
    parameter int unsigned WD_CYCLES = 3000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [7:0] field_in,
    input wire logic [3:0] field_out,
    input wire logic [7:0] led_in,
    input wire logic [3:0] led_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [15:0] idle_q;
    // Cycles since the last access; it trails the design's own count.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || s_axi_bvalid || (s_axi_arvalid && s_axi_arready))
            idle_q <= 16'h0000;
        else if (idle_q != 16'hFFFF)
            idle_q <= idle_q + 16'h0001;
    end
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence b_answer;
        ##[1:2] s_axi_bvalid;
    endsequence
    chk_led_mirror: assert property (led_out == field_out)
        else $error("led_out off");
    chk_filter_rise: assert property ($rose(led_in[0]) |->
        $past(field_in[0], 5) && $past(field_in[0], 8)) else $error("in1 pulse");
    chk_filter_fall: assert property ($fell(led_in[0]) |->
        !$past(field_in[0], 5) && !$past(field_in[0], 8)) else $error("in1 gap");
    chk_in3_filter: assert property ($rose(led_in[2]) |->
        $past(field_in[2], 5) && $past(field_in[2], 8)) else $error("in3 pulse");
    chk_in8_filter: assert property ($fell(led_in[7]) |->
        !$past(field_in[7], 5) && !$past(field_in[7], 8)) else $error("in8 gap");
    chk_wd_outputs_off: assert property (idle_q > WD_CYCLES + 8 |-> field_out == 4'h0)
        else $error("outputs on after timeout");
    chk_write_answer: assert property (aw_w_taken |-> b_answer)
        else $error("late bvalid");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late rvalid");
    chk_write_stall: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during B");
endmodule // mio_slot_mux_checker
bind mio_slot_mux mio_slot_mux_checker #(.WD_CYCLES(WD_CYCLES)) chk (.*);

// *** tb/mio_host_model.sv ***
// Host model: AXI4-Lite master noting each expected answer in a queue.
// Assumes the bench checks tmo after each wr or rd call.
module mio_host_model (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rq[$];
    logic [1:0] erq[$];
    logic [1:0] bq[$];
    bit tmo = 1'b0;
    // Idle bus; whole words only, so all strobes stay set.
    initial
    begin
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end
    // One write: address and data together, each dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 200);
        s_axi_bready <= 1'b0;
        tmo = (n >= 200);
    endtask
    // One read; rready held until the data is seen.
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        rq.push_back(d);
        erq.push_back(r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 200);
        s_axi_rready <= 1'b0;
        tmo = (n >= 200);
    endtask
endmodule // mio_host_model

// *** tb/mio_slot_mux_tb_top.sv ***
// Self-checking bench of the slot block; field pins driven here.
// Assumes the design, host model and checker are compiled first.
`include "mio_defs.svh"
module mio_slot_mux_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned WD = 3000;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [7:0] s_axi_awaddr, s_axi_araddr, led_in;
    logic [7:0] field_in = 8'h00;
    logic [3:0] s_axi_wstrb, field_out, led_out;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [11:0] adc_ch7 = 12'h000, adc_ch8 = 12'h000;
    logic [15:0] seed = 16'h69A8;
    int num_errors = 0;
    int n_tests = 0;
    always #5 aclk = ~aclk;
    mio_slot_mux #(.WD_CYCLES(WD), .FILT_DEF_CYCLES(8), .FCW(20)) uut (.*);
    mio_host_model host (.*);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // A bus wait that ran out counts and ends the run.
    task automatic hung();
        if (host.tmo)
        begin
            num_errors++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        host.wr(a, d, r);
        hung();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        host.rd(a, d, r);
        hung();
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic outs(input logic [3:0] e);
        cmp("field_out", {28'h0, e}, {28'h0, field_out});
        cmp("led_out", {28'h0, e}, {28'h0, led_out});
    endtask
    // Bus answers are judged against the host's oldest note.
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
        begin
            cmp("rdata", host.rq.pop_front(), s_axi_rdata);
            cmp("rresp", {30'h0, host.erq.pop_front()}, {30'h0, s_axi_rresp});
        end
        if (s_axi_bvalid && s_axi_bready)
            cmp("bresp", {30'h0, host.bq.pop_front()}, {30'h0, s_axi_bresp});
    end
    // Main sequence; idle stretches stay inside the watchdog until its test.
    initial
    begin
        logic [7:0] r;
        logic [1:0] m;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        idle(2);
        rd(`MIO_OFS_SLOT_CFG, 32'h0);
        rd(`MIO_OFS_PWM_DUTY, 32'h0);
        rd(`MIO_OFS_FILT_TIME, 32'h8);
        rd(`MIO_OFS_IRQ_MASK, 32'h0);
        rd(8'h30, 32'h0, `MIO_RESP_SLVERR);
        wr(`MIO_OFS_STATUS, 32'hF, `MIO_RESP_SLVERR);
        outs(4'h0);
        wr(`MIO_OFS_PWM_DUTY, 32'hFFFFFFFF);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            m = i[1:0];
            wr(`MIO_OFS_SLOT_CFG, {28'h0, m, m});
            wr(`MIO_OFS_OUT_CTRL, {28'h0, seed[3:0]});
            idle(4);
            outs({(m == 2'h1) ? seed[3:2] : {2{m == 2'h2}}, (m != 2'h0) ? seed[1:0] : 2'b00});
        end
        wr(`MIO_OFS_SLOT_CFG, 32'h08);
        for (int k = 0; k < 2; k++)
        begin
            wr(`MIO_OFS_PWM_DUTY, (k == 0) ? 32'hFFFF0000 : 32'h0000FFFF);
            repeat (3)
            begin
                seed = lfsr(seed);
                idle(5 + seed[6:0]);
                outs((k == 0) ? 4'h8 : 4'h4);
            end
        end
        wr(`MIO_OFS_OUT_CTRL, 32'h0);
        wr(`MIO_OFS_SLOT_CFG, 32'h97);
        seed = lfsr(seed);
        r = seed[7:0];
        field_in <= r;
        idle(16);
        cmp("led_in", {24'h0, r}, {24'h0, led_in});
        rd(`MIO_OFS_STATUS, {24'h0, r});
        cmp("irq", 32'h0, {31'h0, irq});
        wr(`MIO_OFS_IRQ_MASK, 32'h2);
        idle(3);
        cmp("irq", 32'h1, {31'h0, irq});
        wr(`MIO_OFS_IRQ_STAT, 32'h3);
        idle(3);
        cmp("irq", 32'h0, {31'h0, irq});
        wr(`MIO_OFS_SLOT_CFG, 32'h0);
        rd(`MIO_OFS_STATUS, 32'h0);
        field_in <= r ^ 8'h01;
        idle(4);
        field_in <= r;
        idle(20);
        cmp("led_in", {24'h0, r}, {24'h0, led_in});
        field_in <= 8'h02;
        idle(16);
        wr(`MIO_OFS_SLOT_CFG, 32'h2);
        for (int k = 0; k < 7; k++)
        begin
            field_in <= {6'h0, k < 5, 1'b1};
            idle(6);
            field_in <= {6'h0, k < 4, 1'b0};
            idle(6);
        end
        rd(`MIO_OFS_POSITION, 32'h3);
        wr(`MIO_OFS_SLOT_CFG, 32'h1);
        field_in <= 8'h04;
        idle(16);
        rd(`MIO_OFS_LATCHED, 32'h3);
        wr(`MIO_OFS_LATCH_CFG, 32'h1);
        idle(3);
        rd(`MIO_OFS_POSITION, 32'h0);
        field_in <= 8'h00;
        idle(16);
        wr(`MIO_OFS_FILT_TIME, 32'h5);
        rd(`MIO_OFS_FILT_TIME, 32'h3E8);
        field_in <= 8'h09;
        idle(500);
        cmp("led_in", 32'h01, {24'h0, led_in});
        idle(600);
        cmp("led_in", 32'h09, {24'h0, led_in});
        seed = lfsr(seed);
        adc_ch7 <= seed[11:0];
        adc_ch8 <= ~seed[11:0];
        wr(`MIO_OFS_SLOT_CFG, 32'h40);
        idle(4);
        rd(`MIO_OFS_ANALOG, {4'h0, ~seed[11:0], 4'h0, seed[11:0]});
        wr(`MIO_OFS_SLOT_CFG, 32'h97);
        rd(`MIO_OFS_ANALOG, 32'h0);
        wr(`MIO_OFS_OUT_CTRL, 32'hF);
        wr(`MIO_OFS_IRQ_STAT, 32'h3);
        wr(`MIO_OFS_IRQ_MASK, 32'h1);
        idle(4);
        outs(4'hF);
        cmp("irq", 32'h0, {31'h0, irq});
        idle(WD + 20);
        outs(4'h0);
        cmp("irq", 32'h1, {31'h0, irq});
        rd(`MIO_OFS_IRQ_STAT, 32'h1);
        wr(`MIO_OFS_IRQ_STAT, 32'h1);
        idle(3);
        cmp("irq", 32'h0, {31'h0, irq});
        end_of_test();
    end
endmodule // mio_slot_mux_tb_top
